// ### logic/usb_out_ep_ctrl.sv
// out endpoint control and status logic with its packet fifo
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// plain synchronous fifo, valid/ready on both sides
module out_pkt_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_ff;
  logic [AW:0] rptr_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // extra pointer bit tells full from empty
  assign out_valid = (wptr_ff != rptr_ff);
  assign in_ready = !((wptr_ff[AW] != rptr_ff[AW]) &&
                      (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]));
  assign out_data = mem[rptr_ff[AW-1:0]];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (push) wptr_ff <= wptr_ff + 1'b1;
      if (pop) rptr_ff <= rptr_ff + 1'b1;
    end
  end
endmodule

// Overview of operation
// - writing one to clear_toggle zeroes the data toggle and the bit reads 0.
// - every stall handshake sent sets stall_sent_flag until software clears it.
// - while send_stall_ctrl is one, out requests are answered with stall.
// - in isochronous mode send_stall_ctrl has no effect on the answer.
// - a flush write drops the oldest queued packet, pops its bytes up to the end mark, clears ready.
// - the flush bit clears itself once the flush has finished.
// - an isochronous packet with no room is dropped and sets overrun_flag.
// - overrun_flag stays set from the first lost packet until cleared.
// - full shows two packets when double buffered, else one packet.
// - a bulk packet received sets out_packet_ready and raises an event.
// - with two packets queued, ready sets again after software clears it.
// - the iso enable picks bulk/interrupt at zero, isochronous at one.
// - an iso packet with crc error is stored, flagged ready and data error.
module usb_out_ep_ctrl
  import usb_out_ep_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // packet engine: one out token plus data packet
  input wire logic link_sop,
  input wire logic link_valid,
  output logic link_ready,
  input wire logic [7:0] link_data,
  input wire logic link_eop,
  input wire logic link_crc_err,
  // handshake answers and toggle state
  output logic resp_ack,
  output logic resp_nak,
  output logic resp_stall,
  output logic data_toggle,
  // packet unload port
  output logic out_rd_valid,
  input wire logic out_rd_ready,
  output logic [7:0] out_rd_data,
  output logic out_rd_last,
  // event to the controller interrupt block
  output logic ep_event
);
  rx_state_t rx_state_ff, nxt_rx_state;
  logic stall_sent_ff, send_stall_ff, flush_ff, data_err_ff, overrun_ff;
  logic pkt_ready_ff, toggle_ff, dbuf_ff, iso_ff;
  logic [1:0] pkt_cnt_ff, nxt_pkt_cnt;
  logic ack_ff, nak_ff, stall_ff, event_ff;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [FIFO_WIDTH-1:0] fifo_out_data;
  logic [7:0] csr_rd, mode_rd;

  // apb decode; zero wait state, unmapped access errors
  wire csr_hit = (paddr == CSR_ADDR);
  wire mode_hit = (paddr == MODE_ADDR);
  wire acc = psel && penable;
  wire wr_csr = acc && pwrite && csr_hit;
  wire wr_mode = acc && pwrite && mode_hit;
  assign pready = acc;
  assign pslverr = acc && !(csr_hit || mode_hit);

  // software events decoded from a control/status write
  wire sw_clr_toggle = wr_csr && pwdata[B_CLR_TOGGLE];
  wire sw_clr_stall_sent = wr_csr && !pwdata[B_STALL_SENT];
  wire sw_clr_overrun = wr_csr && !pwdata[B_OVERRUN];
  wire sw_clr_ready = wr_csr && !pwdata[B_PKT_READY] && pkt_ready_ff &&
                      !flush_ff;
  wire sw_clr_data_err = (wr_csr && !pwdata[B_DATA_ERR]) || sw_clr_ready;
  // flush only starts when a packet is there to drop
  wire sw_flush = wr_csr && pwdata[B_FLUSH] && !flush_ff &&
                  (pkt_cnt_ff != PKT_CNT_RST);

  // full level follows the buffering mode
  wire [1:0] pkt_limit = dbuf_ff ? PKTS_DOUBLE : PKTS_SINGLE;
  wire fifo_full_pkts = (pkt_cnt_ff >= pkt_limit);
  // stall only counts outside isochronous mode
  wire stall_eff = send_stall_ff && !iso_ff;

  // packet end outcomes; the end mark counts only once its byte is taken,
  // so a last byte held back by a full fifo is neither lost nor counted
  wire eop_taken = link_eop && link_valid && link_ready;
  wire eop_store = eop_taken && (rx_state_ff == RX_STORE);
  wire eop_drop = eop_taken && (rx_state_ff == RX_DROP);
  wire eop_stall = eop_taken && (rx_state_ff == RX_STALL);
  wire set_data_err = eop_store && iso_ff && link_crc_err;
  wire set_overrun = eop_drop && iso_ff;

  // flush drains words up to the packet end mark
  wire flush_pop = flush_ff && fifo_out_valid;
  wire flush_done = flush_pop && fifo_out_data[8];
  assign fifo_out_ready = flush_ff || out_rd_ready;
  assign out_rd_valid = fifo_out_valid && !flush_ff;
  assign out_rd_data = fifo_out_data[7:0];
  assign out_rd_last = fifo_out_data[8];

  // bytes of a dropped packet are sunk so the link never hangs
  wire store_byte = (rx_state_ff == RX_STORE) && link_valid;
  assign link_ready = (rx_state_ff == RX_STORE) ? fifo_in_ready : 1'b1;

  out_pkt_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(store_byte),
    .in_ready(fifo_in_ready),
    .in_data({link_eop, link_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // receive decision is made at the token so no byte needs rewinding
  always_comb begin
    nxt_rx_state = rx_state_ff;
    case (rx_state_ff)
      RX_IDLE: begin
        if (link_sop && stall_eff) begin
          nxt_rx_state = RX_STALL;
        end else if (link_sop && fifo_full_pkts) begin
          nxt_rx_state = RX_DROP;
        end else if (link_sop) begin
          nxt_rx_state = RX_STORE;
        end
      end
      RX_STORE, RX_DROP, RX_STALL: begin
        if (eop_taken) nxt_rx_state = RX_IDLE;
      end
      default: nxt_rx_state = RX_IDLE;
    endcase
  end

  // packet count: one in per stored packet, one out per ready clear or flush
  always_comb begin
    nxt_pkt_cnt = pkt_cnt_ff;
    if (eop_store && !(sw_clr_ready || flush_done)) begin
      nxt_pkt_cnt = pkt_cnt_ff + 2'h1;
    end else if (!eop_store && (sw_clr_ready || flush_done)) begin
      nxt_pkt_cnt = pkt_cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_ff <= RX_IDLE;
      pkt_cnt_ff <= PKT_CNT_RST;
    end else begin
      rx_state_ff <= nxt_rx_state;
      pkt_cnt_ff <= nxt_pkt_cnt;
    end
  end

  // sticky flags; a hardware set wins over a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_sent_ff <= CSR_RST[B_STALL_SENT];
      data_err_ff <= CSR_RST[B_DATA_ERR];
      overrun_ff <= CSR_RST[B_OVERRUN];
    end else begin
      if (eop_stall) stall_sent_ff <= 1'b1;
      else if (sw_clr_stall_sent) stall_sent_ff <= 1'b0;
      if (set_data_err) data_err_ff <= 1'b1;
      else if (sw_clr_data_err) data_err_ff <= 1'b0;
      if (set_overrun) overrun_ff <= 1'b1;
      else if (sw_clr_overrun) overrun_ff <= 1'b0;
    end
  end

  // software controls, flush bit and mode bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_stall_ff <= CSR_RST[B_SEND_STALL];
      flush_ff <= CSR_RST[B_FLUSH];
      dbuf_ff <= MODE_RST[1];
      iso_ff <= MODE_RST[0];
    end else begin
      if (wr_csr) send_stall_ff <= pwdata[B_SEND_STALL];
      if (sw_flush) flush_ff <= 1'b1;
      else if (flush_done) flush_ff <= 1'b0;
      if (wr_mode) begin
        dbuf_ff <= pwdata[B_DBUF_EN];
        iso_ff <= pwdata[B_ISO_EN];
      end
    end
  end

  // packet ready drops for one cycle on clear, so a second packet
  // shows as a fresh rising edge and a fresh event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_ready_ff <= CSR_RST[B_PKT_READY];
    end else if (sw_clr_ready || flush_ff) begin
      pkt_ready_ff <= 1'b0;
    end else if (pkt_cnt_ff != PKT_CNT_RST) begin
      pkt_ready_ff <= 1'b1;
    end
  end

  // data toggle flips on every acknowledged bulk packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_ff <= 1'b0;
    end else if (sw_clr_toggle) begin
      toggle_ff <= 1'b0;
    end else if (eop_store && !iso_ff) begin
      toggle_ff <= !toggle_ff;
    end
  end

  // handshakes; isochronous packets get no handshake at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff <= 1'b0;
      nak_ff <= 1'b0;
      stall_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      ack_ff <= eop_store && !iso_ff;
      nak_ff <= eop_drop && !iso_ff;
      stall_ff <= eop_stall;
      event_ff <= eop_stall || set_overrun ||
                  (!pkt_ready_ff && !sw_clr_ready && !flush_ff &&
                   (pkt_cnt_ff != PKT_CNT_RST));
    end
  end
  assign resp_ack = ack_ff;
  assign resp_nak = nak_ff;
  assign resp_stall = stall_ff;
  assign data_toggle = toggle_ff;
  assign ep_event = event_ff;

  // read view; clear_toggle and unused bits read as zero
  assign csr_rd = {1'b0, stall_sent_ff, send_stall_ff, flush_ff,
                   data_err_ff, overrun_ff, fifo_full_pkts,
                   pkt_ready_ff};
  assign mode_rd = {dbuf_ff, iso_ff, 6'h00};
  assign prdata = csr_hit ? {24'h000000, csr_rd} :
                  mode_hit ? {24'h000000, mode_rd} : 32'h00000000;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_toggle_clear: assert property (
    sw_clr_toggle |=> !data_toggle && (csr_rd[B_CLR_TOGGLE] == 1'b0))
    else $error("toggle not cleared");
  a_stall_sent_flag: assert property (
    resp_stall |-> stall_sent_ff)
    else $error("stall sent flag missing");
  a_stall_answer: assert property (
    (rx_state_ff == RX_IDLE) && link_sop && send_stall_ff && !iso_ff
    |=> rx_state_ff == RX_STALL)
    else $error("stall not answered");
  a_iso_no_stall: assert property (
    (rx_state_ff == RX_IDLE) && link_sop && iso_ff |=>
    rx_state_ff != RX_STALL)
    else $error("stall in iso mode");
  a_flush_clears: assert property (
    flush_ff |=> !pkt_ready_ff && !(flush_ff && out_rd_valid))
    else $error("flush left packet visible");
  a_flush_ends: assert property (
    $fell(flush_ff) && !$past(eop_store) |->
    pkt_cnt_ff == $past(pkt_cnt_ff) - 2'h1)
    else $error("flush did not drop one packet");
  a_overrun_set: assert property (
    eop_drop && iso_ff |=> overrun_ff && !resp_nak)
    else $error("overrun not flagged");
  a_overrun_holds: assert property (
    overrun_ff && !sw_clr_overrun |=> overrun_ff)
    else $error("overrun lost");
  a_full_single: assert property (
    dbuf_ff && pkt_cnt_ff == PKTS_SINGLE |-> !csr_rd[B_FULL])
    else $error("double buffer full too early");
  a_ready_again: assert property (
    sw_clr_ready && pkt_cnt_ff == PKTS_DOUBLE && !eop_store |=>
    !pkt_ready_ff ##1 pkt_ready_ff && ep_event)
    else $error("second packet not flagged");
  a_bulk_ready: assert property (
    eop_store && !iso_ff && !sw_clr_ready && !flush_ff && !sw_flush
    |=> ##[0:1] pkt_ready_ff)
    else $error("packet ready not set");
  a_iso_crc: assert property (
    set_data_err |=> data_err_ff && pkt_cnt_ff != PKT_CNT_RST)
    else $error("crc packet not kept");

  c_bulk_packet: cover property (eop_store && !iso_ff);
  c_stall_sent: cover property (resp_stall);
  c_iso_overrun: cover property (set_overrun);
  c_flush_done: cover property (flush_done);
endmodule

`default_nettype wire

// ### logic/usb_out_ep_pkg.sv
// constants, register layout and state types for the out endpoint control
`default_nettype none

package usb_out_ep_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] CSR_IDX = 8'h14;
  localparam logic [7:0] MODE_IDX = 8'h15;
  localparam logic [11:0] CSR_ADDR = {2'h0, CSR_IDX, 2'h0};
  localparam logic [11:0] MODE_ADDR = {2'h0, MODE_IDX, 2'h0};
  // out_ep_ctrl_status_reg fields
  localparam int B_CLR_TOGGLE = 7;
  localparam int B_STALL_SENT = 6;
  localparam int B_SEND_STALL = 5;
  localparam int B_FLUSH = 4;
  localparam int B_DATA_ERR = 3;
  localparam int B_OVERRUN = 2;
  localparam int B_FULL = 1;
  localparam int B_PKT_READY = 0;
  // out_ep_mode_reg fields
  localparam int B_DBUF_EN = 7;
  localparam int B_ISO_EN = 6;
  // reset values
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] PKT_CNT_RST = 2'h0;
  // fifo shape: one data byte plus an end-of-packet mark
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;
  // packets held when full, single and double buffered
  localparam logic [1:0] PKTS_SINGLE = 2'h1;
  localparam logic [1:0] PKTS_DOUBLE = 2'h2;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_STORE = 2'b01,
    RX_DROP = 2'b10,
    RX_STALL = 2'b11
  } rx_state_t;
endpackage

`default_nettype wire

// ### dv/usb_host_model.sv
// behavioural usb host that pushes out packets into the endpoint
`timescale 1ns/1ps
`default_nettype none

module usb_host_model (
  // clock
  input wire logic pclk,
  // packet stream towards the endpoint
  output logic link_sop,
  output logic link_valid,
  input wire logic link_ready,
  output logic [7:0] link_data,
  output logic link_eop,
  output logic link_crc_err
);
  int hangs = 0;

  // idle levels at time zero
  initial begin
    link_sop = 1'b0;
    link_valid = 1'b0;
    link_data = 8'h00;
    link_eop = 1'b0;
    link_crc_err = 1'b0;
  end

  // token, then n bytes base+i; returns at the edge taking the last byte
  task automatic send(input int n, input logic [7:0] base, input logic crc);
    int i;
    int k;
    @(posedge pclk);
    link_sop <= 1'b1;
    @(posedge pclk);
    link_sop <= 1'b0;
    for (i = 0; i < n; i++) begin
      link_valid <= 1'b1;
      link_data <= base + 8'(i);
      link_eop <= (i == n - 1);
      link_crc_err <= crc & (i == n - 1);
      @(posedge pclk);
      // a full fifo holds the byte back; bounded so a stuck link shows
      for (k = 0; k < 200 && link_ready !== 1'b1; k++)
        @(posedge pclk);
      if (k == 200)
        hangs++;
    end
    // released line shows the inverse so a stale byte is never trusted
    link_valid <= 1'b0;
    link_eop <= 1'b0;
    link_crc_err <= 1'b0;
    link_data <= ~link_data;
  endtask
endmodule

`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the out endpoint control block
`timescale 1ns/1ps
`default_nettype none

module tb
  import usb_out_ep_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic link_sop, link_valid, link_ready, link_eop, link_crc_err;
  logic [7:0] link_data, out_rd_data;
  logic resp_ack, resp_nak, resp_stall, data_toggle, ep_event;
  logic out_rd_valid, out_rd_ready, out_rd_last;
  int fails = 0, comparisons = 0, evts = 0, e0, k;

  usb_out_ep_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_sop(link_sop), .link_valid(link_valid), .link_ready(link_ready),
    .link_data(link_data), .link_eop(link_eop),
    .link_crc_err(link_crc_err), .resp_ack(resp_ack), .resp_nak(resp_nak),
    .resp_stall(resp_stall), .data_toggle(data_toggle),
    .out_rd_valid(out_rd_valid), .out_rd_ready(out_rd_ready),
    .out_rd_data(out_rd_data), .out_rd_last(out_rd_last),
    .ep_event(ep_event));
  usb_host_model host (.pclk(pclk), .link_sop(link_sop),
    .link_valid(link_valid), .link_ready(link_ready),
    .link_data(link_data), .link_eop(link_eop),
    .link_crc_err(link_crc_err));

  // clock and event counter
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) if (ep_event === 1'b1) evts++;

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one apb transfer; waits for pready, never assumes a latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int j;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (j = 0; j < 50 && pready !== 1'b1; j++)
      @(posedge pclk);
    if (j == 50) begin
      fails++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(a == CSR_ADDR ? "csr" : "mode", rd, 32'(e));
  endtask

  // send a packet and judge the masked handshake {ack,nak,stall}
  task automatic pkt(input int n, input logic [7:0] b, input logic crc,
                     input logic [2:0] e, input logic [2:0] m);
    host.send(n, b, crc);
    #1;
    chk("resp", 32'({resp_ack, resp_nak, resp_stall} & m), 32'(e));
  endtask

  // unload n bytes with the reader stalling every other cycle
  task automatic drain(input int n, input logic [7:0] b);
    int i;
    int j;
    i = 0;
    for (j = 0; j < 200 && i < n; j++) begin
      out_rd_ready <= j[0];
      @(posedge pclk);
      if (out_rd_valid === 1'b1 && out_rd_ready === 1'b1) begin
        chk("rd_data", 32'(out_rd_data), 32'(b + 8'(i)));
        chk("rd_last", 32'(out_rd_last), 32'(i == n - 1));
        i++;
      end
    end
    out_rd_ready <= 1'b0;
    if (i < n) begin
      fails++;
      test_done();
    end
  endtask

  task automatic t_reset();
    rchk(CSR_ADDR, 8'h00);
    rchk(MODE_ADDR, 8'h00);
    apb(1'b1, MODE_ADDR, 8'hff);
    rchk(MODE_ADDR, 8'hc0);
    apb(1'b1, MODE_ADDR, 8'h00);
    apb(1'b0, 12'h058, 8'h00);
    chk("pslverr", 32'(err), 32'h1);
    chk("unmapped", rd, 32'h0);
  endtask

  task automatic t_bulk();
    pkt(2, 8'h30, 1'b0, 3'b100, 3'b111);
    chk("toggle", 32'(data_toggle), 32'h1);
    rchk(CSR_ADDR, 8'h03);
    pkt(1, 8'h40, 1'b0, 3'b010, 3'b111);
    drain(2, 8'h30);
    apb(1'b1, CSR_ADDR, 8'h80);
    #1;
    chk("toggle", 32'(data_toggle), 32'h0);
    rchk(CSR_ADDR, 8'h00);
  endtask

  task automatic t_stall();
    apb(1'b1, CSR_ADDR, 8'h20);
    pkt(2, 8'h50, 1'b0, 3'b001, 3'b111);
    rchk(CSR_ADDR, 8'h60);
    apb(1'b1, CSR_ADDR, 8'h00);
    pkt(1, 8'h58, 1'b0, 3'b100, 3'b111);
    drain(1, 8'h58);
    apb(1'b1, CSR_ADDR, 8'h00);
  endtask

  // second packet waits on a full fifo while the reader drains the first
  task automatic t_dbuf();
    apb(1'b1, MODE_ADDR, 8'h80);
    e0 = evts;
    pkt(8, 8'h10, 1'b0, 3'b100, 3'b111);
    fork
      pkt(4, 8'h20, 1'b0, 3'b100, 3'b111);
      drain(8, 8'h10);
    join
    drain(4, 8'h20);
    rchk(CSR_ADDR, 8'h03);
    apb(1'b1, CSR_ADDR, 8'h00);
    rchk(CSR_ADDR, 8'h01);
    chk("events", 32'(evts - e0), 32'h2);
    apb(1'b1, CSR_ADDR, 8'h00);
    rchk(CSR_ADDR, 8'h00);
    apb(1'b1, MODE_ADDR, 8'h00);
  endtask

  task automatic t_flush();
    pkt(3, 8'h60, 1'b0, 3'b100, 3'b111);
    apb(1'b1, CSR_ADDR, 8'h11);
    for (k = 0; k < 20; k++) begin
      apb(1'b0, CSR_ADDR, 8'h00);
      if (rd[4] === 1'b0)
        break;
    end
    chk("flush_done", 32'(k < 20), 32'h1);
    chk("csr", rd, 32'h0);
    chk("rd_valid", 32'(out_rd_valid), 32'h0);
    pkt(1, 8'h70, 1'b0, 3'b100, 3'b111);
    drain(1, 8'h70);
    apb(1'b1, CSR_ADDR, 8'h00);
  endtask

  task automatic t_iso();
    apb(1'b1, MODE_ADDR, 8'h40);
    apb(1'b1, CSR_ADDR, 8'h20);
    pkt(2, 8'h80, 1'b1, 3'b000, 3'b001);
    rchk(CSR_ADDR, 8'h2b);
    pkt(1, 8'h90, 1'b0, 3'b000, 3'b001);
    rchk(CSR_ADDR, 8'h2f);
    pkt(1, 8'h98, 1'b0, 3'b000, 3'b001);
    rchk(CSR_ADDR, 8'h2f);
    drain(2, 8'h80);
    apb(1'b1, CSR_ADDR, 8'h00);
    rchk(CSR_ADDR, 8'h00);
    rchk(MODE_ADDR, 8'h40);
    apb(1'b1, MODE_ADDR, 8'h00);
  endtask

  // reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    out_rd_ready = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bulk();
    t_stall();
    t_dbuf();
    t_flush();
    t_iso();
    chk("host_hangs", 32'(host.hangs), 32'h0);
    test_done();
  end
endmodule

`default_nettype wire
